// ==== common/pilu_pkg.sv ====
// constants for the prioritized interrupt latch unit
package pilu_pkg;
    // ----------------------------------------
    // register byte addresses in the sfr space
    // ----------------------------------------
    localparam logic [7:0] ADDR_LATCH_UPPER = 8'h2e;
    localparam logic [7:0] ADDR_LATCH_LOW = 8'h3c;
    localparam logic [7:0] ADDR_LATCH_HIGH = 8'h3d;
    localparam logic [7:0] ADDR_ENABLE_UPPER = 8'h2c;
    localparam logic [7:0] ADDR_ENABLE_LOW = 8'h3a;
    localparam logic [7:0] ADDR_ENABLE_HIGH = 8'h3b;
    // ----------------------------------------
    // source slots and field positions
    // ----------------------------------------
    localparam int NUM_SLOTS = 24;
    localparam int NUM_LATCHED = 20;
    localparam int SLOT_SOFT_TRAP = 1;
    localparam int SLOT_FETCH_TRAP = 2;
    localparam int SLOT_WATCHDOG = 3;
    localparam int SLOT_FIRST_MASKABLE = 4;
    localparam int SLOT_EXT0 = 5;
    localparam int SLOT_CONVERSION_DONE = 15;
    localparam int SLOT_UPPER_BASE = 16;
    localparam int BIT_MASTER_ENABLE = 0;
    // ----------------------------------------
    // fixed priorities (lower wins)
    // ----------------------------------------
    localparam int PRIO_RESET = 1;
    localparam int PRIO_NONMASKABLE = 2;
    localparam int PRIO_MASKABLE_BASE = 5;
    // ----------------------------------------
    // vectors
    // ----------------------------------------
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_SOFT_TRAP = 16'hfffc;
    localparam logic [15:0] VEC_UPPER_TOP = 16'hffbe;
    // ----------------------------------------
    // reset values and timing
    // ----------------------------------------
    localparam logic [23:0] LATCH_RESET = 24'h000000;
    localparam logic [23:0] ENABLE_RESET = 24'h000000;
    localparam logic MASTER_RESET = 1'b0;
    localparam int ACCEPT_MCYCLES = 8;
    localparam int MCYCLE_CLKS = 4;
    localparam int STACK_BYTES = 3;
endpackage

// ==== logic/pilu_prio_pick.sv ====
// fixed-priority pick of the winning request and its vector
`timescale 1ns/10ps
module pilu_prio_pick #(
    parameter int NUM = 24
) (
    input wire logic [NUM-1:0] i_req,
    output logic o_valid,
    output logic [4:0] o_index,
    output logic [15:0] o_vector
);
    // lowest slot wins; slots 1 to 3 share one level, lowest index breaks the tie
    always_comb begin
        o_valid = 1'b0;
        o_index = 5'h00;
        for (int i = NUM - 1; i >= 1; i--) begin
            if (i_req[i]) begin
                o_valid = 1'b1;
                o_index = 5'(i);
            end
        end
    end

    // slots below 16 step down from the reset vector, upper slots from their own top
    always_comb begin
        if (o_index < 5'(pilu_pkg::SLOT_UPPER_BASE)) begin
            o_vector = pilu_pkg::VEC_RESET - {10'h000, o_index, 1'b0};
        end else begin
            o_vector = pilu_pkg::VEC_UPPER_TOP
                - {10'h000, 5'(o_index - 5'(pilu_pkg::SLOT_UPPER_BASE)), 1'b0};
        end
    end
endmodule

// ==== logic/pilu_top.sv ====
// interrupt latches, enables, priority pick and acceptance sequence
`timescale 1ns/10ps
module pilu_top #(
    parameter int NUM_LATCHED = pilu_pkg::NUM_LATCHED,
    parameter int MCYCLE_CLKS = pilu_pkg::MCYCLE_CLKS
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    input wire logic [pilu_pkg::NUM_SLOTS-1:0] i_src_request,
    input wire logic i_ext0_pin_enable,
    input wire logic i_soft_trap_event,
    input wire logic i_illegal_opcode_event,
    input wire logic i_fetch_trap_event,
    input wire logic i_watchdog_event,
    input wire logic i_trap_action_select,
    input wire logic i_watchdog_action_select,
    input wire logic i_insn_done,
    input wire logic i_irq_enable_op,
    input wire logic i_irq_disable_op,
    input wire logic i_return_op,
    input wire logic i_return_imf,
    output logic o_irq_pending,
    output logic o_accept_busy,
    output logic o_accept_done,
    output logic [15:0] o_vector,
    output logic o_stacked_imf,
    output logic [1:0] o_stack_bytes,
    output logic o_reset_request
);
    localparam int ACC_CLKS = pilu_pkg::ACCEPT_MCYCLES * MCYCLE_CLKS;
    localparam logic [7:0] ACC_LAST = 8'(ACC_CLKS - 1);

    typedef enum logic [1:0] {
        PILU_IDLE = 2'b01,
        PILU_ACCEPT = 2'b10
    } pilu_state_type;

    pilu_state_type state;
    logic [7:0] acc_cnt;
    logic [23:0] pend;
    logic [23:0] en;
    logic master_irq_enable;
    logic soft_req;
    logic [23:0] hw_set;
    logic [23:0] sw_clr;
    logic [23:0] req;
    logic pick_valid;
    logic [4:0] pick_idx;
    logic [15:0] pick_vec;
    logic start;

    // ----------------------------------------
    // request sources
    // ----------------------------------------
    // trap and watchdog only latch when action select picks the interrupt
    always_comb begin
        hw_set = i_src_request;
        hw_set[pilu_pkg::SLOT_SOFT_TRAP-1:0] = '0;
        hw_set[pilu_pkg::SLOT_SOFT_TRAP] = 1'b0;
        hw_set[pilu_pkg::SLOT_FETCH_TRAP] = i_fetch_trap_event & ~i_trap_action_select;
        hw_set[pilu_pkg::SLOT_WATCHDOG] = i_watchdog_event & ~i_watchdog_action_select;
    end

    // ----------------------------------------
    // software clear decode
    // ----------------------------------------
    always_comb begin
        sw_clr = 24'h000000;
        if (i_sfr_wr && i_sfr_addr == pilu_pkg::ADDR_LATCH_LOW) begin
            sw_clr[7:2] = ~i_sfr_wdata[7:2];
        end else if (i_sfr_wr && i_sfr_addr == pilu_pkg::ADDR_LATCH_HIGH) begin
            sw_clr[15:8] = ~i_sfr_wdata;
        end else if (i_sfr_wr && i_sfr_addr == pilu_pkg::ADDR_LATCH_UPPER) begin
            sw_clr[19:16] = ~i_sfr_wdata[3:0];
        end
    end

    // ----------------------------------------
    // pending latches
    // ----------------------------------------
    // only the captured winner is cleared, so a conversion-done request is never lost
    genvar g;
    generate
        for (g = 0; g < 24; g++) begin : gen_latch
            if (g >= pilu_pkg::SLOT_FETCH_TRAP && g < NUM_LATCHED) begin : gen_real
                always_ff @(posedge i_clk) begin
                    if (i_reset) begin
                        pend[g] <= pilu_pkg::LATCH_RESET[g];
                    end else if (i_ce) begin
                        if (hw_set[g]) begin
                            pend[g] <= 1'b1;
                        end else if (start && pick_idx == 5'(g)) begin
                            pend[g] <= 1'b0;
                        end else if (sw_clr[g]) begin
                            pend[g] <= 1'b0;
                        end
                    end
                end
            end else begin : gen_none
                assign pend[g] = 1'b0;
            end
        end
    endgenerate

    // non-latched soft trap and illegal opcode, held until accepted
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            soft_req <= 1'b0;
        end else if (i_ce) begin
            if (i_soft_trap_event || i_illegal_opcode_event) begin
                soft_req <= 1'b1;
            end else if (start && pick_idx == 5'(pilu_pkg::SLOT_SOFT_TRAP)) begin
                soft_req <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // enables
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            en <= pilu_pkg::ENABLE_RESET;
        end else if (i_ce && i_sfr_wr) begin
            if (i_sfr_addr == pilu_pkg::ADDR_ENABLE_LOW) begin
                en[7:4] <= i_sfr_wdata[7:4];
            end else if (i_sfr_addr == pilu_pkg::ADDR_ENABLE_HIGH) begin
                en[15:8] <= i_sfr_wdata;
            end else if (i_sfr_addr == pilu_pkg::ADDR_ENABLE_UPPER) begin
                en[19:16] <= i_sfr_wdata[3:0];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            master_irq_enable <= pilu_pkg::MASTER_RESET;
        end else if (i_ce) begin
            if (start) begin
                master_irq_enable <= 1'b0;
            end else if (i_irq_disable_op) begin
                master_irq_enable <= 1'b0;
            end else if (i_irq_enable_op) begin
                master_irq_enable <= 1'b1;
            end else if (i_return_op) begin
                master_irq_enable <= i_return_imf;
            end else if (i_sfr_wr && i_sfr_addr == pilu_pkg::ADDR_ENABLE_LOW) begin
                master_irq_enable <= i_sfr_wdata[pilu_pkg::BIT_MASTER_ENABLE];
            end
        end
    end

    // ----------------------------------------
    // gating and priority
    // ----------------------------------------
    always_comb begin
        req = pend & en & {24{master_irq_enable}};
        req[pilu_pkg::SLOT_EXT0] = req[pilu_pkg::SLOT_EXT0] & i_ext0_pin_enable;
        req[pilu_pkg::SLOT_FIRST_MASKABLE-1:0] = 4'h0;
        req[pilu_pkg::SLOT_SOFT_TRAP] = soft_req;
        req[pilu_pkg::SLOT_FETCH_TRAP] = pend[pilu_pkg::SLOT_FETCH_TRAP];
        req[pilu_pkg::SLOT_WATCHDOG] = pend[pilu_pkg::SLOT_WATCHDOG];
    end

    pilu_prio_pick #(
        .NUM(24)
    ) u_pick (
        .i_req(req),
        .o_valid(pick_valid),
        .o_index(pick_idx),
        .o_vector(pick_vec)
    );

    assign start = i_ce && state == PILU_IDLE && i_insn_done && pick_valid;

    // ----------------------------------------
    // acceptance sequence
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= PILU_IDLE;
            acc_cnt <= 8'h00;
            o_accept_busy <= 1'b0;
            o_accept_done <= 1'b0;
            o_vector <= pilu_pkg::VEC_RESET;
            o_stacked_imf <= 1'b0;
            o_stack_bytes <= 2'h0;
        end else if (i_ce) begin
            o_accept_done <= 1'b0;
            case (state)
                PILU_IDLE: begin
                    if (start) begin
                        state <= PILU_ACCEPT;
                        acc_cnt <= 8'h00;
                        o_accept_busy <= 1'b1;
                        o_vector <= pick_vec;
                        o_stacked_imf <= master_irq_enable;
                        o_stack_bytes <= 2'(pilu_pkg::STACK_BYTES);
                    end
                end
                PILU_ACCEPT: begin
                    if (acc_cnt == ACC_LAST) begin
                        state <= PILU_IDLE;
                        o_accept_busy <= 1'b0;
                        o_accept_done <= 1'b1;
                    end else begin
                        acc_cnt <= acc_cnt + 8'h01;
                    end
                end
                default: begin
                    state <= PILU_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // status outputs and register reads
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_irq_pending <= 1'b0;
            o_reset_request <= 1'b0;
        end else if (i_ce) begin
            o_irq_pending <= pick_valid;
            o_reset_request <= (i_fetch_trap_event & i_trap_action_select)
                | (i_watchdog_event & i_watchdog_action_select);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_sfr_rdata <= 8'h00;
        end else if (i_ce) begin
            if (i_sfr_rd && i_sfr_addr == pilu_pkg::ADDR_LATCH_LOW) begin
                o_sfr_rdata <= {pend[7:2], 2'b00};
            end else if (i_sfr_rd && i_sfr_addr == pilu_pkg::ADDR_LATCH_HIGH) begin
                o_sfr_rdata <= pend[15:8];
            end else if (i_sfr_rd && i_sfr_addr == pilu_pkg::ADDR_LATCH_UPPER) begin
                o_sfr_rdata <= {4'h0, pend[19:16]};
            end else if (i_sfr_rd && i_sfr_addr == pilu_pkg::ADDR_ENABLE_LOW) begin
                o_sfr_rdata <= {en[7:4], 3'b000, master_irq_enable};
            end else if (i_sfr_rd && i_sfr_addr == pilu_pkg::ADDR_ENABLE_HIGH) begin
                o_sfr_rdata <= en[15:8];
            end else if (i_sfr_rd && i_sfr_addr == pilu_pkg::ADDR_ENABLE_UPPER) begin
                o_sfr_rdata <= {4'h0, en[19:16]};
            end else begin
                o_sfr_rdata <= 8'h00;
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_begin;
        start;
    endsequence

    sequence s_body;
        o_accept_busy [*8];
    endsequence

    a_set_beats_clear: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_ce && hw_set[9] && sw_clr[9]) |=> pend[9])
        else $error("latch lost a request against a clear");
    a_accept_clears_latch: assert property (@(posedge i_clk) disable iff (i_reset)
        (start && pick_idx == 5'd9 && !hw_set[9]) |=> !pend[9])
        else $error("accepted latch not cleared");
    a_accept_clears_master: assert property (@(posedge i_clk) disable iff (i_reset)
        s_begin |=> (!master_irq_enable && o_accept_busy))
        else $error("master enable not cleared on acceptance");
    a_accept_length: assert property (@(posedge i_clk) disable iff (i_reset || !i_ce)
        s_begin ##1 s_body |-> ##(ACC_CLKS - 7) (o_accept_done && !o_accept_busy))
        else $error("acceptance length wrong");
    a_mask_gate: assert property (@(posedge i_clk) disable iff (i_reset)
        (start && pick_idx >= 5'd4) |-> (master_irq_enable && en[pick_idx]))
        else $error("maskable accepted while disabled");
    a_nmi_first: assert property (@(posedge i_clk) disable iff (i_reset)
        (start && (pend[2] || pend[3] || soft_req)) |-> pick_idx < 5'd4)
        else $error("maskable beat a non-maskable request");
    a_vector_taken: assert property (@(posedge i_clk) disable iff (i_reset)
        (start && pick_idx == 5'd16) |=> o_vector == 16'hffbe)
        else $error("wrong vector for slot sixteen");
    a_write_one_noset: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_ce && !pend[10] && !hw_set[10]) |=> !pend[10])
        else $error("latch set without a request");
    a_reset_clears: assert property (@(posedge i_clk)
        i_reset |=> (pend == 24'h000000 && !master_irq_enable && en == 24'h000000))
        else $error("reset left state set");
endmodule

// ==== dv/pilu_cpu_model.sv ====
// cpu side model: instruction completion strobe and accepted vector log
`timescale 1ns/10ps
module pilu_cpu_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_slow,
    input wire logic i_accept_done,
    input wire logic [15:0] i_vector,
    output logic o_insn_done,
    output logic [15:0] o_last_vector
);
    logic [1:0] gap;
    initial begin
        gap = 2'h0;
        o_insn_done = 1'b0;
        o_last_vector = 16'h0000;
    end
    // one instruction a cycle, or one in four when slow; silent in reset
    always @(negedge i_clk) begin
        gap <= gap + 2'h1;
        o_insn_done <= !i_reset && (!i_slow || gap == 2'h3);
        if (i_accept_done) begin
            o_last_vector <= i_vector;
        end
    end
endmodule

// ==== dv/test_prioritized_interrupt_latch_unit.sv ====
// self-checking bench for the interrupt latch unit
`timescale 1ns/10ps
module test_prioritized_interrupt_latch_unit;
    localparam logic [6:0] EV_SOFT = 7'h40, EV_ILL = 7'h20, EV_FETCH = 7'h10, EV_WD = 7'h08;
    localparam logic [6:0] EV_EN = 7'h04, EV_DIS = 7'h02, EV_RET = 7'h01;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [23:0] src = 24'h000000;
    logic [6:0] ev = 7'h00;
    logic ext0_en = 1'b0;
    logic trap_sel = 1'b1;
    logic wd_sel = 1'b1;
    logic slow = 1'b0;
    logic ret_imf = 1'b0;
    logic ce = 1'b1;
    logic irq_pend;
    logic [7:0] sfr_rdata;
    logic insn_done, busy, done, stacked_imf, reset_req;
    logic [15:0] vector, last_vector;
    logic [1:0] stack_bytes;
    int mismatches = 0;
    int samples_checked = 0;

    pilu_top pilu_top_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_ce(ce), .i_sfr_addr(sfr_addr),
        .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd), .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata),
        .i_src_request(src), .i_ext0_pin_enable(ext0_en), .i_soft_trap_event(ev[6]),
        .i_illegal_opcode_event(ev[5]), .i_fetch_trap_event(ev[4]), .i_watchdog_event(ev[3]),
        .i_trap_action_select(trap_sel), .i_watchdog_action_select(wd_sel),
        .i_insn_done(insn_done), .i_irq_enable_op(ev[2]), .i_irq_disable_op(ev[1]),
        .i_return_op(ev[0]), .i_return_imf(ret_imf), .o_irq_pending(irq_pend),
        .o_accept_busy(busy),
        .o_accept_done(done), .o_vector(vector), .o_stacked_imf(stacked_imf),
        .o_stack_bytes(stack_bytes), .o_reset_request(reset_req)
    );
    pilu_cpu_model pilu_cpu_model_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_slow(slow), .i_accept_done(done),
        .i_vector(vector), .o_insn_done(insn_done), .o_last_vector(last_vector)
    );

    initial begin
        forever #12.5 i_clk = ~i_clk;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge i_clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge i_clk);
        sfr_rd = 1'b0;
        check(24'(sfr_rdata), 24'(e));
    endtask
    task automatic pulse(input logic [6:0] e, input logic [23:0] s);
        @(negedge i_clk);
        ev = e;
        src = s;
        @(negedge i_clk);
        ev = 7'h00;
        src = 24'h000000;
    endtask
    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge i_clk);
            check(24'(busy), 24'h000000);
        end
    endtask
    task automatic accept(input logic [15:0] v, input logic master_irq_enable);
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 200) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 200) begin
            mismatches++;
            close_out();
        end
        check(24'(vector), 24'(v));
        check(24'(irq_pend), 24'h000001);
        check(24'(stacked_imf), 24'(master_irq_enable));
        check(24'(stack_bytes), 24'(pilu_pkg::STACK_BYTES));
        n = 0;
        while (busy === 1'b1 && n < 100) begin
            @(negedge i_clk);
            n++;
        end
        check(24'(n), 24'(pilu_pkg::ACCEPT_MCYCLES * pilu_pkg::MCYCLE_CLKS));
        check(24'(done), 24'h000001);
        @(negedge i_clk);
        check(24'(done), 24'h000000);
        check(24'(last_vector), 24'(v));
    endtask
    function automatic logic [15:0] vec_of(input int s);
        if (s < 16) return 16'hfffe - 16'(2 * s);
        return 16'hffbe - 16'(2 * (s - 16));
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        check(24'(vector), 24'h00fffe);
        rd_chk(8'h3c, 8'h00);
        rd_chk(8'h3d, 8'h00);
        rd_chk(8'h2e, 8'h00);
        rd_chk(8'h3a, 8'h00);
        rd_chk(8'h3b, 8'h00);
        rd_chk(8'h2c, 8'h00);
    endtask
    task automatic t_latch();
        pulse(7'h00, 24'h0ffff0);
        rd_chk(8'h3c, 8'hf0);
        rd_chk(8'h3d, 8'hff);
        rd_chk(8'h2e, 8'h0f);
        wr(8'h3c, 8'hff);
        wr(8'h2e, 8'hff);
        rd_chk(8'h3c, 8'hf0);
        rd_chk(8'h2e, 8'h0f);
        wr(8'h3c, 8'h5c);
        wr(8'h3d, 8'h0f);
        wr(8'h2e, 8'h05);
        rd_chk(8'h3c, 8'h50);
        rd_chk(8'h3d, 8'h0f);
        rd_chk(8'h2e, 8'h05);
        rd_chk(8'h3e, 8'h00);
        wr(8'h3c, 8'h0c);
        wr(8'h3d, 8'h00);
        wr(8'h2e, 8'h00);
        rd_chk(8'h3c, 8'h00);
    endtask
    task automatic t_set_wins();
        pulse(7'h00, 24'h000600);
        @(negedge i_clk);
        sfr_addr = 8'h3d;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b1;
        src = 24'h000200;
        @(negedge i_clk);
        sfr_wr = 1'b0;
        src = 24'h000000;
        rd_chk(8'h3d, 8'h02);
        wr(8'h3d, 8'h00);
    endtask
    task automatic t_mask();
        pulse(7'h00, 24'h000200);
        wr(8'h3b, 8'h02);
        quiet(8);
        check(24'(irq_pend), 24'h000000);
        pulse(EV_EN, 24'h000000);
        accept(16'hffec, 1'b1);
        rd_chk(8'h3d, 8'h00);
        pulse(7'h00, 24'h000200);
        quiet(8);
        pulse(EV_EN | EV_DIS, 24'h000000);
        quiet(8);
        ret_imf = 1'b1;
        pulse(EV_RET, 24'h000000);
        ret_imf = 1'b0;
        accept(16'hffec, 1'b1);
    endtask
    task automatic t_prio();
        pulse(7'h00, 24'h0ffff0);
        ext0_en = 1'b1;
        wr(8'h3b, 8'hff);
        wr(8'h2c, 8'h0f);
        wr(8'h3a, 8'hf0);
        for (int s = 4; s < 20; s++) begin
            pulse(EV_EN, 24'h000000);
            accept(vec_of(s), 1'b1);
        end
        pulse(7'h00, 24'h080000);
        pulse(EV_EN, 24'h000000);
        accept(16'hffb8, 1'b1);
        pulse(7'h00, 24'h000010);
        pulse(EV_EN, 24'h000000);
        accept(16'hfff6, 1'b1);
        wr(8'h3a, 8'h00);
        wr(8'h3b, 8'h00);
        wr(8'h2c, 8'h00);
    endtask
    task automatic t_nonmask();
        trap_sel = 1'b0;
        wd_sel = 1'b0;
        slow = 1'b1;
        pulse(EV_SOFT | EV_FETCH | EV_WD, 24'h000000);
        accept(16'hfffc, 1'b0);
        accept(16'hfffa, 1'b0);
        accept(16'hfff8, 1'b0);
        pulse(EV_ILL, 24'h000000);
        accept(16'hfffc, 1'b0);
        slow = 1'b0;
        trap_sel = 1'b1;
        wd_sel = 1'b1;
        pulse(EV_FETCH, 24'h000000);
        check(24'(reset_req), 24'h000001);
        pulse(EV_WD, 24'h000000);
        check(24'(reset_req), 24'h000001);
        rd_chk(8'h3c, 8'h00);
    endtask
    task automatic t_conversion();
        wr(8'h2c, 8'h01);
        pulse(EV_EN, 24'h000000);
        @(negedge i_clk);
        src = 24'h010000;
        @(negedge i_clk);
        src = 24'h008000;
        @(negedge i_clk);
        src = 24'h000000;
        accept(16'hffbe, 1'b1);
        rd_chk(8'h3d, 8'h80);
        wr(8'h3d, 8'h00);
    endtask
    task automatic t_freeze();
        ce = 1'b0;
        pulse(EV_EN, 24'h000800);
        ce = 1'b1;
        rd_chk(8'h3d, 8'h00);
        rd_chk(8'h3a, 8'h00);
    endtask
    task automatic t_rereset();
        pulse(7'h00, 24'h0ffff0);
        @(negedge i_clk);
        i_reset = 1'b1;
        @(negedge i_clk);
        i_reset = 1'b0;
        check(24'(vector), 24'h00fffe);
        rd_chk(8'h3c, 8'h00);
        rd_chk(8'h3d, 8'h00);
        rd_chk(8'h2e, 8'h00);
        rd_chk(8'h2c, 8'h00);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(negedge i_clk);
        i_reset = 1'b0;
        t_reset();
        t_latch();
        t_set_wins();
        t_mask();
        t_prio();
        t_nonmask();
        t_conversion();
        t_freeze();
        t_rereset();
        close_out();
    end
endmodule
